//--- hdl/abspt_ctrl.sv
// Host controller that fetches the absolute position from a servo amplifier
// Functional notes
// - Servo-on switch rising edge starts transfer
// - Held switch: start at power-on, run edge
// - Alarm clear or stop release restarts transfer
// - Servo-on asserted before any transfer begins
// - Checksum mismatch retries whole transfer, three max
// - Retries exhausted raise checksum error, stop
// - Time mode, request, ready-off; flag link error
// - Torque limiting kept off during transfer
// - No motion until transfer completes
// - Two bits per exchange into 32-bit value
// - Wait delay before sampling data lines
// - Mode held off for wait before retry
// - Pairs counted, data pairs summed, checksum compared
// - Deviation clear driven by controller output
// - Nineteen two-bit exchanges per transfer
// - Clear pulses 100 ms only for home set
module abspt_ctrl #(
  parameter int CYC_PER_MS = abspt_pkg::CYC_PER_MS
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        servo_on_switch_i,
  input  wire logic        run_i,
  input  wire logic        servo_alarm_i,
  input  wire logic        emergency_stop_i,
  input  wire logic        ready_to_send_in_i,
  input  wire logic        data_bit0_in_i,
  input  wire logic        data_bit1_in_i,
  output logic             servo_on_input_o,
  output logic             transfer_mode_out_o,
  output logic             transfer_request_out_o,
  output logic             checksum_error_out_o,
  output logic             link_error_out_o,
  output logic             deviation_clear_o,
  output logic             torque_limit_en_o,
  output logic             motion_enable_o,
  output logic             in_position_o,
  output logic             zero_speed_o,
  output logic             torque_limiting_o
);
  abspt_pkg::abspt_state_t state_r;
  logic [31:0] raw_pos_r;
  logic [31:0] cur_pos_r;
  logic [31:0] home_addr_r;
  logic [5:0]  checksum_sum_reg;
  logic [5:0]  cks_rx_r;
  logic [1:0]  pair_receive_buffer;
  logic [1:0]  retry_count_reg;
  logic [4:0]  pair_cnt_r;
  logic        cks_err_r;
  logic        link_err_r;
  logic        clr_r;
  logic        trq_req_r;
  logic        start_pend_r;
  logic        boot_r;
  logic        son_d_r;
  logic        run_d_r;
  logic        alm_d_r;
  logic        estop_d_r;
  logic [16:0] presc_r;
  logic        tick_r;
  logic        wb_hit;
  logic        home_set_cmd;
  logic        err_clr_cmd;
  logic        xfer;
  logic        start_evt;
  logic        read_delay_done;
  logic        retry_wait_done;
  logic        mode_to;
  logic        req_to;
  logic        rts_to;
  logic        clr_done;
  logic        timeout;
  logic        cks_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond time base
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc_r <= '0;
      tick_r  <= 1'b0;
    end else if (presc_r == 17'(CYC_PER_MS - 1)) begin
      presc_r <= '0;
      tick_r  <= 1'b1;
    end else begin
      presc_r <= presc_r + 1'b1;
      tick_r  <= 1'b0;
    end
  end

  abspt_timer #(.W(abspt_pkg::MS_W)) u_read_delay_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .run_i   (state_r == abspt_pkg::ABSPT_DELAY),
    .tick_i  (tick_r),
    .limit_i (abspt_pkg::READ_DELAY_MS),
    .done_o  (read_delay_done)
  );

  abspt_timer #(.W(abspt_pkg::MS_W)) u_retry_off_wait_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .run_i   (state_r == abspt_pkg::ABSPT_RETRY_WAIT),
    .tick_i  (tick_r),
    .limit_i (abspt_pkg::RETRY_OFF_MS),
    .done_o  (retry_wait_done)
  );

  abspt_timer #(.W(abspt_pkg::MS_W)) u_mode_on_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .run_i   (transfer_mode_out_o),
    .tick_i  (tick_r),
    .limit_i (abspt_pkg::MODE_ON_MS),
    .done_o  (mode_to)
  );

  abspt_timer #(.W(abspt_pkg::MS_W)) u_req_on_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .run_i   (state_r == abspt_pkg::ABSPT_REQ),
    .tick_i  (tick_r),
    .limit_i (abspt_pkg::REQ_ON_MS),
    .done_o  (req_to)
  );

  abspt_timer #(.W(abspt_pkg::MS_W)) u_rts_off_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .run_i   (state_r == abspt_pkg::ABSPT_REL || state_r == abspt_pkg::ABSPT_MODE_WAIT),
    .tick_i  (tick_r),
    .limit_i (abspt_pkg::RTS_OFF_MS),
    .done_o  (rts_to)
  );

  abspt_timer #(.W(abspt_pkg::MS_W)) u_clear_on_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .run_i   (clr_r),
    .tick_i  (tick_r),
    .limit_i (abspt_pkg::CLEAR_ON_MS),
    .done_o  (clr_done)
  );

  assign timeout = mode_to || req_to || rts_to;
  assign cks_ok  = (checksum_sum_reg == cks_rx_r);

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave
  assign wb_hit       = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign home_set_cmd = wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == abspt_pkg::ADR_CTRL
                        && wb_dat_i[abspt_pkg::CTRL_HOME_SET];
  assign err_clr_cmd  = wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == abspt_pkg::ADR_CTRL
                        && wb_dat_i[abspt_pkg::CTRL_ERR_CLR];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit && !wb_we_i) begin
        case (wb_adr_i)
          abspt_pkg::ADR_CTRL:  wb_dat_o <= {29'h0000_0000, trq_req_r, 2'b00};
          abspt_pkg::ADR_STAT:  wb_dat_o <= {16'h0000, 3'b000, pair_cnt_r, retry_count_reg,
                                             state_r, link_err_r, cks_err_r};
          abspt_pkg::ADR_POS:   wb_dat_o <= cur_pos_r;
          abspt_pkg::ADR_HOME:  wb_dat_o <= home_addr_r;
          abspt_pkg::ADR_RAW:   wb_dat_o <= raw_pos_r;
          abspt_pkg::ADR_CKSUM: wb_dat_o <= {16'h0000, 2'b00, cks_rx_r, 2'b00, checksum_sum_reg};
          default:              wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      home_addr_r <= 32'h0000_0000;
      trq_req_r   <= 1'b0;
    end else if (wb_hit && wb_we_i) begin
      if (wb_adr_i == abspt_pkg::ADR_HOME) begin
        for (int b = 0; b < 4; b++) begin
          if (wb_sel_i[b]) begin
            home_addr_r[8*b +: 8] <= wb_dat_i[8*b +: 8];
          end
        end
      end
      if (wb_adr_i == abspt_pkg::ADR_CTRL && wb_sel_i[0]) begin
        trq_req_r <= wb_dat_i[abspt_pkg::CTRL_TRQ_LIMIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start triggers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      son_d_r   <= 1'b0;
      run_d_r   <= 1'b0;
      alm_d_r   <= 1'b0;
      estop_d_r <= 1'b0;
      boot_r    <= 1'b1;
    end else begin
      son_d_r   <= servo_on_switch_i;
      run_d_r   <= run_i;
      alm_d_r   <= servo_alarm_i;
      estop_d_r <= emergency_stop_i;
      boot_r    <= 1'b0;
    end
  end

  assign start_evt = (servo_on_switch_i && !son_d_r)
                     || (servo_on_switch_i && (boot_r || (run_i && !run_d_r)))
                     || (servo_on_switch_i && ((alm_d_r && !servo_alarm_i)
                         || (estop_d_r && !emergency_stop_i)));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_pend_r <= 1'b0;
    end else if (start_evt) begin
      start_pend_r <= 1'b1;
    end else if (state_r == abspt_pkg::ABSPT_MODE_WAIT || !servo_on_switch_i) begin
      start_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      servo_on_input_o <= 1'b0;
    end else begin
      servo_on_input_o <= servo_on_switch_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequence
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r                <= abspt_pkg::ABSPT_IDLE;
      transfer_mode_out_o    <= 1'b0;
      transfer_request_out_o <= 1'b0;
      pair_cnt_r             <= '0;
      retry_count_reg        <= abspt_pkg::RETRIES;
    end else begin
      case (state_r)
        abspt_pkg::ABSPT_IDLE, abspt_pkg::ABSPT_DONE: begin
          if (start_pend_r && servo_on_input_o) begin
            state_r             <= abspt_pkg::ABSPT_MODE_WAIT;
            transfer_mode_out_o <= 1'b1;
            retry_count_reg     <= abspt_pkg::RETRIES;
            pair_cnt_r          <= '0;
          end
        end
        abspt_pkg::ABSPT_MODE_WAIT: begin
          if (ready_to_send_in_i) begin
            state_r                <= abspt_pkg::ABSPT_REQ;
            transfer_request_out_o <= 1'b1;
          end
        end
        abspt_pkg::ABSPT_REQ: begin
          if (!ready_to_send_in_i) begin
            state_r <= abspt_pkg::ABSPT_DELAY;
          end
        end
        abspt_pkg::ABSPT_DELAY: begin
          if (read_delay_done) begin
            state_r                <= abspt_pkg::ABSPT_REL;
            transfer_request_out_o <= 1'b0;
          end
        end
        abspt_pkg::ABSPT_REL: begin
          if (ready_to_send_in_i) begin
            if (pair_cnt_r == abspt_pkg::LAST_PAIR) begin
              state_r <= abspt_pkg::ABSPT_CHECK;
            end else begin
              pair_cnt_r             <= pair_cnt_r + 1'b1;
              state_r                <= abspt_pkg::ABSPT_REQ;
              transfer_request_out_o <= 1'b1;
            end
          end
        end
        abspt_pkg::ABSPT_CHECK: begin
          transfer_mode_out_o <= 1'b0;
          if (cks_ok) begin
            state_r <= abspt_pkg::ABSPT_DONE;
          end else if (retry_count_reg != 2'b00) begin
            retry_count_reg <= retry_count_reg - 1'b1;
            state_r         <= abspt_pkg::ABSPT_RETRY_WAIT;
          end else begin
            state_r <= abspt_pkg::ABSPT_FAULT;
          end
        end
        abspt_pkg::ABSPT_RETRY_WAIT: begin
          if (retry_wait_done) begin
            state_r             <= abspt_pkg::ABSPT_MODE_WAIT;
            transfer_mode_out_o <= 1'b1;
            pair_cnt_r          <= '0;
          end
        end
        abspt_pkg::ABSPT_FAULT: begin
          if (err_clr_cmd) begin
            state_r <= abspt_pkg::ABSPT_IDLE;
          end
        end
        default: begin
          state_r <= abspt_pkg::ABSPT_IDLE;
        end
      endcase
      if (timeout) begin
        state_r                <= abspt_pkg::ABSPT_FAULT;
        transfer_mode_out_o    <= 1'b0;
        transfer_request_out_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data and checksum assembly
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pair_receive_buffer <= 2'b00;
      raw_pos_r           <= 32'h0000_0000;
      cks_rx_r            <= 6'h00;
      checksum_sum_reg    <= 6'h00;
    end else if (state_r == abspt_pkg::ABSPT_MODE_WAIT) begin
      cks_rx_r         <= 6'h00;
      checksum_sum_reg <= 6'h00;
    end else if (state_r == abspt_pkg::ABSPT_DELAY && read_delay_done) begin
      pair_receive_buffer <= {data_bit1_in_i, data_bit0_in_i};
      if (pair_cnt_r < abspt_pkg::DATA_PAIRS) begin
        raw_pos_r        <= {data_bit1_in_i, data_bit0_in_i, raw_pos_r[31:2]};
        checksum_sum_reg <= checksum_sum_reg + {4'h0, data_bit1_in_i, data_bit0_in_i};
      end else begin
        cks_rx_r <= {data_bit1_in_i, data_bit0_in_i, cks_rx_r[5:2]};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_pos_r <= 32'h0000_0000;
    end else if (state_r == abspt_pkg::ABSPT_CHECK && cks_ok) begin
      cur_pos_r <= raw_pos_r + home_addr_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error flags: a new error wins over a clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cks_err_r  <= 1'b0;
      link_err_r <= 1'b0;
    end else begin
      if (state_r == abspt_pkg::ABSPT_CHECK && !cks_ok && retry_count_reg == 2'b00) begin
        cks_err_r <= 1'b1;
      end else if (err_clr_cmd) begin
        cks_err_r <= 1'b0;
      end
      if (timeout) begin
        link_err_r <= 1'b1;
      end else if (err_clr_cmd) begin
        link_err_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clear pulse, motion and shared status outputs
  assign xfer = (state_r != abspt_pkg::ABSPT_IDLE) && (state_r != abspt_pkg::ABSPT_DONE)
                && (state_r != abspt_pkg::ABSPT_FAULT);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clr_r <= 1'b0;
    end else if (clr_done) begin
      clr_r <= 1'b0;
    end else if (home_set_cmd && state_r == abspt_pkg::ABSPT_DONE) begin
      clr_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      checksum_error_out_o <= 1'b0;
      link_error_out_o     <= 1'b0;
      deviation_clear_o    <= 1'b0;
      torque_limit_en_o    <= 1'b0;
      motion_enable_o      <= 1'b0;
      in_position_o        <= 1'b0;
      zero_speed_o         <= 1'b0;
      torque_limiting_o    <= 1'b0;
    end else begin
      checksum_error_out_o <= cks_err_r;
      link_error_out_o     <= link_err_r;
      deviation_clear_o    <= clr_r && !clr_done;
      torque_limit_en_o    <= trq_req_r && !xfer;
      motion_enable_o      <= state_r == abspt_pkg::ABSPT_DONE && servo_on_input_o;
      in_position_o        <= !transfer_mode_out_o && data_bit0_in_i;
      zero_speed_o         <= !transfer_mode_out_o && data_bit1_in_i;
      torque_limiting_o    <= !transfer_mode_out_o && ready_to_send_in_i;
    end
  end
endmodule // abspt_ctrl

//--- hdl/abspt_pkg.sv
// Constants, register map and states of the absolute position transfer controller
package abspt_pkg;
  // Clock and time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_MS     = 1000000;
  localparam int CYC_PER_MS    = NS_PER_MS / CLK_PERIOD_NS;
  localparam int MS_W          = 13;

  // Times in milliseconds
  localparam logic [MS_W-1:0] READ_DELAY_MS = 13'd10;
  localparam logic [MS_W-1:0] RETRY_OFF_MS  = 13'd20;
  localparam logic [MS_W-1:0] CLEAR_ON_MS   = 13'd100;
  localparam logic [MS_W-1:0] MODE_ON_MS    = 13'd5000;
  localparam logic [MS_W-1:0] REQ_ON_MS     = 13'd1000;
  localparam logic [MS_W-1:0] RTS_OFF_MS    = 13'd1000;

  // Transfer shape
  localparam logic [4:0] LAST_PAIR  = 5'd18;
  localparam logic [4:0] DATA_PAIRS = 5'd16;
  localparam logic [1:0] RETRIES    = 2'd3;

  // Register word offsets (byte addresses)
  localparam logic [7:0] ADR_CTRL  = 8'h00;
  localparam logic [7:0] ADR_STAT  = 8'h04;
  localparam logic [7:0] ADR_POS   = 8'h08;
  localparam logic [7:0] ADR_HOME  = 8'h0C;
  localparam logic [7:0] ADR_RAW   = 8'h10;
  localparam logic [7:0] ADR_CKSUM = 8'h14;

  // Control register bits
  localparam int CTRL_HOME_SET  = 0;
  localparam int CTRL_ERR_CLR   = 1;
  localparam int CTRL_TRQ_LIMIT = 2;

  typedef enum logic [3:0] {
    ABSPT_IDLE,
    ABSPT_MODE_WAIT,
    ABSPT_REQ,
    ABSPT_DELAY,
    ABSPT_REL,
    ABSPT_CHECK,
    ABSPT_RETRY_WAIT,
    ABSPT_DONE,
    ABSPT_FAULT
  } abspt_state_t;
endpackage : abspt_pkg

//--- hdl/abspt_timer.sv
// Millisecond interval timer: counts ticks while running, flags reaching its limit
module abspt_timer #(
  parameter int W = 13
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         run_i,
  input  wire logic         tick_i,
  input  wire logic [W-1:0] limit_i,
  output logic              done_o
);
  logic [W-1:0] cnt_r;
  logic         armed_r;

  // First tick only arms: a partial interval never counts
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt_r   <= '0;
      armed_r <= 1'b0;
    end else if (tick_i && !armed_r) begin
      armed_r <= 1'b1;
    end else if (tick_i && cnt_r != limit_i) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign done_o = run_i && (cnt_r == limit_i);
endmodule // abspt_timer

//--- testbench/abspt_ctrl_asserts.sv
// Port-level concurrent checks for the absolute position transfer controller
module abspt_ctrl_asserts #(
  parameter int CYC_PER_MS = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_ack_o,
  input wire logic ready_to_send_in_i,
  input wire logic data_bit0_in_i,
  input wire logic data_bit1_in_i,
  input wire logic servo_on_input_o,
  input wire logic transfer_mode_out_o,
  input wire logic transfer_request_out_o,
  input wire logic checksum_error_out_o,
  input wire logic link_error_out_o,
  input wire logic deviation_clear_o,
  input wire logic torque_limit_en_o,
  input wire logic motion_enable_o,
  input wire logic in_position_o,
  input wire logic zero_speed_o,
  input wire logic torque_limiting_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] req_len_r;
  logic [15:0] clr_len_r;
  ////////////////////////////////////////////////////////////////////////////
  // Length of the current request, saturating
  always_ff @(posedge clk_i) begin
    if (rst_i || !transfer_request_out_o) req_len_r <= 16'h0000;
    else if (req_len_r != 16'hFFFF) req_len_r <= req_len_r + 16'h0001;
  end
  // Length of the current clear pulse, saturating
  always_ff @(posedge clk_i) begin
    if (rst_i || !deviation_clear_o) clr_len_r <= 16'h0000;
    else if (clr_len_r != 16'hFFFF) clr_len_r <= clr_len_r + 16'h0001;
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_mode_low3; !transfer_mode_out_o [*3]; endsequence
  sequence s_mode_high3; transfer_mode_out_o [*3]; endsequence
  sequence s_err_held; (checksum_error_out_o || link_error_out_o) [*2]; endsequence
  a_servo_first: assert property ($rose(transfer_mode_out_o) |-> servo_on_input_o)
    else $error("transfer mode raised while servo on was low");
  a_trq_off_xfer: assert property (transfer_mode_out_o [*2] |-> !torque_limit_en_o)
    else $error("torque limit enabled during transfer");
  a_still_xfer: assert property (transfer_mode_out_o [*2] |-> !motion_enable_o)
    else $error("motion enabled during transfer");
  a_share_idle: assert property (s_mode_low3 |-> in_position_o == $past(data_bit0_in_i)
    && zero_speed_o == $past(data_bit1_in_i) && torque_limiting_o == $past(ready_to_send_in_i))
    else $error("status lines not passed through outside transfer");
  a_share_xfer: assert property (s_mode_high3 |-> !in_position_o && !zero_speed_o && !torque_limiting_o)
    else $error("status lines not masked during transfer");
  a_req_in_mode: assert property (transfer_request_out_o |-> transfer_mode_out_o)
    else $error("request outside transfer mode");
  a_read_delay: assert property ($fell(transfer_request_out_o) |-> req_len_r >= 10 * CYC_PER_MS)
    else $error("pair sampled before read delay");
  a_clear_len: assert property ($fell(deviation_clear_o)
    |-> clr_len_r >= 100 * CYC_PER_MS && clr_len_r <= 100 * CYC_PER_MS + 2)
    else $error("clear pulse length wrong");
  a_clear_idle: assert property (transfer_mode_out_o |-> !deviation_clear_o)
    else $error("clear asserted during transfer");
  a_err_stops: assert property (s_err_held |-> !transfer_mode_out_o && !transfer_request_out_o)
    else $error("transfer active while error flagged");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule // abspt_ctrl_asserts

bind abspt_ctrl abspt_ctrl_asserts #(.CYC_PER_MS(CYC_PER_MS)) i_abspt_ctrl_asserts (
  .clk_i(clk_i), .rst_i(rst_i), .wb_ack_o(wb_ack_o), .ready_to_send_in_i(ready_to_send_in_i),
  .data_bit0_in_i(data_bit0_in_i), .data_bit1_in_i(data_bit1_in_i), .servo_on_input_o(servo_on_input_o),
  .transfer_mode_out_o(transfer_mode_out_o), .transfer_request_out_o(transfer_request_out_o),
  .checksum_error_out_o(checksum_error_out_o), .link_error_out_o(link_error_out_o),
  .deviation_clear_o(deviation_clear_o), .torque_limit_en_o(torque_limit_en_o),
  .motion_enable_o(motion_enable_o), .in_position_o(in_position_o), .zero_speed_o(zero_speed_o),
  .torque_limiting_o(torque_limiting_o)
);

//--- testbench/abspt_amp_model.sv
// Behavioural servo amplifier answering the position handshake
module abspt_amp_model (
  input  wire logic        clk_i,
  input  wire logic        mode_i,
  input  wire logic        req_i,
  input  wire logic [31:0] pos_i,
  input  wire logic        bad_i,
  input  wire logic        mute_i,
  input  wire logic [2:0]  st_i,
  output logic             rts_o,
  output logic             b0_o,
  output logic             b1_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        rts_r  = 1'b0;
  logic        busy_r = 1'b0;
  logic [4:0]  k_r    = 5'h00;
  logic [5:0]  sum;
  logic [31:0] sh;
  // Current pair: data LSB first, then checksum, corrupted on request
  always_comb begin
    sum = 6'h00;
    for (int i = 0; i < 16; i++) sum += 6'(pos_i[2*i+:2]);
    if (bad_i) sum = ~sum;
    sh = (k_r < 5'h10) ? pos_i >> {k_r, 1'b0} : 32'(sum) >> {k_r - 5'h10, 1'b0};
  end
  always @(posedge clk_i) begin
    if (!mode_i) begin
      rts_r <= 1'b0;
      busy_r <= 1'b0;
      k_r <= 5'h00;
    end else if (mute_i) begin
      rts_r <= 1'b0;
    end else if (!rts_r && !busy_r) begin
      rts_r <= 1'b1;
    end else if (rts_r && req_i) begin
      rts_r <= 1'b0;
      busy_r <= 1'b1;
    end else if (busy_r && !req_i) begin
      busy_r <= 1'b0;
      k_r <= k_r + 5'h01;
    end
  end
  // Data lines show the inverse while no pair is presented
  assign rts_o = mode_i ? rts_r : st_i[2];
  assign b0_o  = mode_i ? sh[0] ^ rts_r : st_i[0];
  assign b1_o  = mode_i ? sh[1] ^ rts_r : st_i[1];
endmodule // abspt_amp_model

//--- testbench/tb.sv
// Self-checking bench for the absolute position transfer controller
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CPM   = 2;
  localparam int LIMIT = 20000;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        we    = 1'b0;
  logic        bad   = 1'b0;
  logic        mute  = 1'b0;
  logic [3:0]  ev    = 4'h1;
  logic [2:0]  st    = 3'h0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] wdat  = 32'h0000_0000;
  logic [31:0] pos   = 32'h2468_ACE1;
  logic [31:0] rdat;
  logic        ack, rts, b0, b1, mode, req, ckerr, lnkerr, dclr, trq, mot;
  logic [31:0] pv [4] = '{32'hFFFF_FFFF, 32'h0000_0000, 32'h8000_0001, 32'h5A5A_C3C3};
  int          n_mismatch   = 0;
  int          total_checks = 0;
  int          cycles       = 0;
  ////////////////////////////////////////////////////////////////////////////
  abspt_ctrl #(.CYC_PER_MS(CPM)) i_abspt_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack), .servo_on_switch_i(ev[0]),
    .run_i(ev[1]), .servo_alarm_i(ev[2]), .emergency_stop_i(ev[3]), .ready_to_send_in_i(rts),
    .data_bit0_in_i(b0), .data_bit1_in_i(b1), .servo_on_input_o(), .transfer_mode_out_o(mode),
    .transfer_request_out_o(req), .checksum_error_out_o(ckerr), .link_error_out_o(lnkerr),
    .deviation_clear_o(dclr), .torque_limit_en_o(trq), .motion_enable_o(mot), .in_position_o(),
    .zero_speed_o(), .torque_limiting_o()
  );
  abspt_amp_model i_abspt_amp_model (
    .clk_i(clk_i), .mode_i(mode), .req_i(req), .pos_i(pos), .bad_i(bad), .mute_i(mute), .st_i(st),
    .rts_o(rts), .b0_o(b0), .b1_o(b1)
  );
  ////////////////////////////////////////////////////////////////////////////
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) st <= st + 3'h1;
  task automatic close_out;
    if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      close_out;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
  endtask
  // Pulse one start source away from its idle level
  task automatic kick(input int k);
    ev <= 4'h1 ^ (4'h1 << k);
    repeat (3) @(posedge clk_i);
    ev <= 4'h1;
  endtask
  task automatic wait_done;
    while (mode !== 1'b1) @(posedge clk_i);
    while (mode === 1'b1 || mot !== 1'b1) @(posedge clk_i);
  endtask
  function automatic logic [5:0] csum(input logic [31:0] p);
    csum = 6'h00;
    for (int i = 0; i < 16; i++) csum += 6'(p[2*i+:2]);
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_boot;
    logic [31:0] q;
    wait_done;
    wb(1'b0, abspt_pkg::ADR_POS, 32'h0000_0000, q);
    chk(q, pos);
    wb(1'b0, abspt_pkg::ADR_RAW, 32'h0000_0000, q);
    chk(q, pos);
    wb(1'b0, abspt_pkg::ADR_CKSUM, 32'h0000_0000, q);
    chk(q, {18'h0_0000, csum(pos), 2'h0, csum(pos)});
  endtask
  task automatic t_regs;
    logic [31:0] q;
    int n = 0;
    wb(1'b1, abspt_pkg::ADR_CTRL, 32'h0000_0004, q);
    @(posedge clk_i);
    chk(32'(trq), 32'h0000_0001);
    wb(1'b0, abspt_pkg::ADR_CTRL, 32'h0000_0000, q);
    chk(q & 32'h0000_0004, 32'h0000_0004);
    wb(1'b0, 8'h3C, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    wb(1'b1, abspt_pkg::ADR_CTRL, 32'h0000_0005, q);
    while (dclr !== 1'b1) @(posedge clk_i);
    while (dclr === 1'b1) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(n >= 100 * CPM && n <= 100 * CPM + 2), 32'h0000_0001);
  endtask
  task automatic t_edges;
    logic [31:0] q;
    wb(1'b1, abspt_pkg::ADR_HOME, 32'h0000_01F4, q);
    wb(1'b0, abspt_pkg::ADR_HOME, 32'h0000_0000, q);
    chk(q, 32'h0000_01F4);
    for (int k = 0; k < 4; k++) begin
      pos <= pv[k];
      kick(k);
      wait_done;
      wb(1'b0, abspt_pkg::ADR_POS, 32'h0000_0000, q);
      chk(q, pv[k] + 32'h0000_01F4);
    end
  endtask
  task automatic t_retry;
    logic [31:0] q;
    logic pm = 1'b0;
    int n = 0, low = 0, gap = 9999;
    bad <= 1'b1;
    kick(0);
    while (ckerr !== 1'b1) begin
      @(posedge clk_i);
      if (mode === 1'b1 && !pm) begin
        n++;
        if (n > 1 && low < gap) gap = low;
      end
      low = (mode === 1'b1) ? 0 : low + 1;
      pm = (mode === 1'b1);
    end
    chk(32'(n), 32'h0000_0004);
    chk(32'(gap >= 20 * CPM), 32'h0000_0001);
    repeat (100) @(posedge clk_i);
    chk(32'(mode), 32'h0000_0000);
    wb(1'b0, abspt_pkg::ADR_STAT, 32'h0000_0000, q);
    chk(q & 32'h0000_0003, 32'h0000_0001);
    chk(q & 32'h0000_1FFC, 32'h0000_1220);
    bad <= 1'b0;
    wb(1'b1, abspt_pkg::ADR_CTRL, 32'h0000_0006, q);
    @(posedge clk_i);
    chk(32'(ckerr), 32'h0000_0000);
    repeat (1000) @(posedge clk_i);
  endtask
  task automatic t_mute;
    logic [31:0] q;
    int n = 0;
    mute <= 1'b1;
    kick(0);
    while (mode !== 1'b1) @(posedge clk_i);
    while (lnkerr !== 1'b1) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(n >= 1000 * CPM && n <= 1000 * CPM + 10), 32'h0000_0001);
    chk(32'(mode), 32'h0000_0000);
    mute <= 1'b0;
    wb(1'b1, abspt_pkg::ADR_CTRL, 32'h0000_0006, q);
    @(posedge clk_i);
    chk(32'(lnkerr), 32'h0000_0000);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_boot;
    t_regs;
    t_edges;
    t_retry;
    t_mute;
    close_out;
  end
endmodule // tb
